// [design/ssx_pkg.sv]
/*
  Shared constants and types for the skip/subtract/swap/xor execution unit.
  Assumes a single 100 MHz clock, a sequencer that issues one command at a time,
  data memory with one-cycle read latency and program memory likewise.
*/
// Notes on behaviour
// [RQ1] decrement-skip-to-work-reg: work reg gets byte minus one; skip when zero
// [RQ2] any taken skip inserts one dummy cycle after the instruction
// [RQ3] set-byte writes FF to the byte; flags untouched
// [RQ4] set-bit forces chosen bit to one, other bits and flags kept
// [RQ5] inc-skip-in-place writes byte plus one back; skip when zero; no flags
// [RQ6] inc-skip-to-work-reg puts byte plus one in work reg; memory kept
// [RQ7] bit-set-skip skips when the chosen bit is one; no flags
// [RQ8] bit-clear-skip skips when the chosen bit is zero; no flags
// [RQ9] zero-test-skip skips when the byte is zero; nothing else changes
// [RQ10] copy-test-skip loads byte into work reg; skip when zero; no flags
// [RQ11] memory subtract: work reg minus byte, to work reg or memory; four flags
// [RQ12] immediate subtract: work reg minus literal into work reg; four flags
// [RQ13] subtract carry is zero on negative result, one otherwise
// [RQ14] nibble exchange swaps byte halves in place; no flags
// [RQ15] nibble exchange to work reg; memory and flags kept
// [RQ16] program word read at table pointer: low to memory, high to latch
// [RQ17] last page word read via low pointer: low to memory, high to latch
// [RQ18] xor with byte or literal into work reg; only zero flag changes
// [RQ19] xor to memory writes result into the byte; only zero flag changes
package ssx_pkg;

    localparam int DATA_W = 8;
    localparam int PROG_DW = 16;
    localparam int DMEM_AW = 8;
    localparam int PROG_AW_DEF = 11;
    localparam int BUS_AW = 5;
    localparam int BUS_DW = 32;

    // register byte offsets
    localparam logic [BUS_AW-1:0] REG_WORK_OFS = 5'h00;
    localparam logic [BUS_AW-1:0] REG_FLAGS_OFS = 5'h04;
    localparam logic [BUS_AW-1:0] REG_PTR_LOW_OFS = 5'h08;
    localparam logic [BUS_AW-1:0] REG_PTR_HIGH_OFS = 5'h0C;
    localparam logic [BUS_AW-1:0] REG_LATCH_OFS = 5'h10;
    localparam logic [BUS_AW-1:0] REG_ENGINE_OFS = 5'h14;

    // field positions in the engine register
    localparam int ENG_BUSY_POS = 0;
    localparam int ENG_SKIP_POS = 1;

    // reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [DATA_W-1:0] PTR_RST = 8'h00;
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hFF;

    typedef enum logic [4:0] {
        OP_DEC_SKIP_TO_WORK_REG,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_INC_SKIP_IN_PLACE,
        OP_INC_SKIP_TO_WORK_REG,
        OP_BIT_SET_SKIP,
        OP_BIT_CLEAR_SKIP,
        OP_ZERO_TEST_SKIP,
        OP_COPY_TEST_SKIP,
        OP_SUBTRACT_TO_WORK_REG,
        OP_SUBTRACT_TO_MEMORY,
        OP_SUBTRACT_IMMEDIATE,
        OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_TO_WORK_REG,
        OP_PROGRAM_WORD_READ,
        OP_LAST_PAGE_WORD_READ,
        OP_EXCLUSIVE_OR_TO_WORK_REG,
        OP_EXCLUSIVE_OR_IMMEDIATE,
        OP_EXCLUSIVE_OR_TO_MEMORY
    } ssx_op_e;

    typedef struct packed {
        ssx_op_e op;
        logic [DMEM_AW-1:0] dataAddr;
        logic [2:0] bitSel;
        logic [DATA_W-1:0] literal;
    } ssx_cmd_s;

    // bit 0 carry, 1 half borrow, 2 zero, 3 signed range
    typedef struct packed {
        logic signedRange;
        logic zero;
        logic halfBorrow;
        logic carry;
    } ssx_flags_s;

endpackage

// [design/ssx_exec_unit.sv]
/*
  Execution unit for skips, bit/byte set, subtract, nibble exchange, table reads
  and exclusive-or. Assumes data and program memories answer one cycle after the
  read enable, and a sequencer that waits on cmdReady between commands.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module ssx_exec_unit #(
    parameter int PROG_AW = ssx_pkg::PROG_AW_DEF,
    parameter bit HAS_HIGH_PTR = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic [ssx_pkg::BUS_AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [ssx_pkg::BUS_DW-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [ssx_pkg::BUS_DW-1:0] readdata,
    output logic waitrequest,
    // instruction sequencer
    input wire logic cmdValid,
    input wire ssx_pkg::ssx_cmd_s cmd,
    output logic cmdReady,
    output logic retireValid,
    output logic skipTaken,
    output logic dummyCycle,
    output logic [ssx_pkg::DATA_W-1:0] workingRegister,
    output ssx_pkg::ssx_flags_s statusFlags,
    // data memory
    output logic [ssx_pkg::DMEM_AW-1:0] memAddr,
    output logic memRdEn,
    input wire logic [ssx_pkg::DATA_W-1:0] memRdData,
    output logic memWrEn,
    output logic [ssx_pkg::DATA_W-1:0] memWrData,
    // program memory
    output logic [PROG_AW-1:0] progAddr,
    output logic progRdEn,
    input wire logic [ssx_pkg::PROG_DW-1:0] progRdData
);
    import ssx_pkg::*;

    generate
        if (PROG_AW < 9 || PROG_AW > 16)
        begin : g_bad_aw
            $error("PROG_AW must lie between 9 and 16");
        end
    endgenerate

    typedef enum logic [2:0] {S_IDLE, S_OPND, S_EXEC, S_RETIRE, S_DUMMY} ssx_state_e;

    ssx_state_e state;
    ssx_cmd_s cmdHold;
    logic [DATA_W-1:0] tablePointerLow;
    logic [DATA_W-1:0] tablePointerHigh;
    logic [DATA_W-1:0] tableHighByteLatch;
    logic lastSkip;
    logic busAck;
    logic busy;
    logic busWrite;
    logic [15:0] ptrPair;
    logic [PROG_AW-1:0] tablePtrAddr;
    logic [PROG_AW-1:0] lastPageAddr;
    logic [DATA_W-1:0] bitMask;
    logic [DATA_W-1:0] incVal;
    logic [DATA_W-1:0] decVal;
    logic [DATA_W-1:0] swapVal;
    logic [DATA_W-1:0] subA;
    logic [DATA_W-1:0] subB;
    logic [DATA_W:0] subFull;
    logic [4:0] halfFull;
    logic [DATA_W-1:0] subRes;
    ssx_flags_s subFlags;
    logic [DATA_W-1:0] xorRes;
    logic [DATA_W-1:0] next_work;
    ssx_flags_s next_flags;
    logic next_memWr;
    logic [DATA_W-1:0] next_memData;
    logic next_skip;
    logic next_latch;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic isImmOp(input ssx_op_e op);
        return op == OP_SUBTRACT_IMMEDIATE || op == OP_EXCLUSIVE_OR_IMMEDIATE;
    endfunction

    function automatic logic isTableOp(input ssx_op_e op);
        return op == OP_PROGRAM_WORD_READ || op == OP_LAST_PAGE_WORD_READ;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    assign busy = state != S_IDLE;
    assign cmdReady = state == S_IDLE;
    assign dummyCycle = state == S_DUMMY;
    assign memRdEn = state == S_OPND && !isImmOp(cmdHold.op) && !isTableOp(cmdHold.op);
    assign progRdEn = state == S_OPND && isTableOp(cmdHold.op);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state <= S_IDLE;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (cmdValid)
                    begin
                        state <= S_OPND;
                    end
                end
                S_OPND: state <= S_EXEC;
                S_EXEC: state <= S_RETIRE;
                // a taken skip turns the next fetch into a dummy cycle
                S_RETIRE: state <= skipTaken ? S_DUMMY : S_IDLE; // [RQ2]
                S_DUMMY: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // pointers sampled at accept; later bus writes affect the next command only
    assign ptrPair = {tablePointerHigh, tablePointerLow};
    assign tablePtrAddr = HAS_HIGH_PTR ? ptrPair[PROG_AW-1:0]
                                       : {{(PROG_AW-8){1'b0}}, tablePointerLow}; // [RQ16]
    assign lastPageAddr = {{(PROG_AW-8){1'b1}}, tablePointerLow}; // [RQ17]

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cmdHold <= '0;
            memAddr <= '0;
            progAddr <= '0;
        end
        else if (state == S_IDLE && cmdValid)
        begin
            cmdHold <= cmd;
            memAddr <= cmd.dataAddr;
            progAddr <= cmd.op == OP_LAST_PAGE_WORD_READ ? lastPageAddr : tablePtrAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic

    assign bitMask = 8'h01 << cmdHold.bitSel;
    assign incVal = memRdData + 8'h01;
    assign decVal = memRdData - 8'h01;
    assign swapVal = {memRdData[3:0], memRdData[7:4]};
    assign subA = workingRegister;
    assign subB = isImmOp(cmdHold.op) ? cmdHold.literal : memRdData;
    assign subFull = {1'b0, subA} - {1'b0, subB};
    assign halfFull = {1'b0, subA[3:0]} - {1'b0, subB[3:0]};
    assign subRes = subFull[DATA_W-1:0];
    assign xorRes = workingRegister ^ subB;

    always_comb
    begin
        subFlags.signedRange = (subA[7] ^ subB[7]) & (subA[7] ^ subRes[7]);
        subFlags.zero = subRes == 8'h00;
        // set means no borrow out of the low nibble
        subFlags.halfBorrow = !halfFull[4];
        subFlags.carry = !subFull[DATA_W]; // [RQ13]
    end

    always_comb
    begin
        next_work = workingRegister;
        next_flags = statusFlags;
        next_memWr = 1'b0;
        next_memData = memRdData;
        next_skip = 1'b0;
        next_latch = 1'b0;
        case (cmdHold.op)
            OP_DEC_SKIP_TO_WORK_REG:
            begin
                next_work = decVal; // [RQ1]
                next_skip = decVal == 8'h00; // [RQ1]
            end
            OP_SET_BYTE:
            begin
                next_memWr = 1'b1;
                next_memData = BYTE_ALL_ONES; // [RQ3]
            end
            OP_SET_BIT:
            begin
                next_memWr = 1'b1;
                next_memData = memRdData | bitMask; // [RQ4]
            end
            OP_INC_SKIP_IN_PLACE:
            begin
                next_memWr = 1'b1;
                next_memData = incVal; // [RQ5]
                next_skip = incVal == 8'h00; // [RQ5]
            end
            OP_INC_SKIP_TO_WORK_REG:
            begin
                next_work = incVal; // [RQ6]
                next_skip = incVal == 8'h00; // [RQ6]
            end
            OP_BIT_SET_SKIP: next_skip = |(memRdData & bitMask); // [RQ7]
            OP_BIT_CLEAR_SKIP: next_skip = !(|(memRdData & bitMask)); // [RQ8]
            OP_ZERO_TEST_SKIP: next_skip = memRdData == 8'h00; // [RQ9]
            OP_COPY_TEST_SKIP:
            begin
                next_work = memRdData; // [RQ10]
                next_skip = memRdData == 8'h00; // [RQ10]
            end
            OP_SUBTRACT_TO_WORK_REG, OP_SUBTRACT_IMMEDIATE:
            begin
                next_work = subRes; // [RQ11] [RQ12]
                next_flags = subFlags;
            end
            OP_SUBTRACT_TO_MEMORY:
            begin
                next_memWr = 1'b1;
                next_memData = subRes; // [RQ11]
                next_flags = subFlags;
            end
            OP_NIBBLE_EXCHANGE:
            begin
                next_memWr = 1'b1;
                next_memData = swapVal; // [RQ14]
            end
            OP_NIBBLE_EXCHANGE_TO_WORK_REG: next_work = swapVal; // [RQ15]
            OP_PROGRAM_WORD_READ, OP_LAST_PAGE_WORD_READ:
            begin
                next_memWr = 1'b1;
                next_memData = progRdData[7:0]; // [RQ16] [RQ17]
                next_latch = 1'b1;
            end
            OP_EXCLUSIVE_OR_TO_WORK_REG, OP_EXCLUSIVE_OR_IMMEDIATE:
            begin
                next_work = xorRes; // [RQ18]
                next_flags.zero = xorRes == 8'h00;
            end
            OP_EXCLUSIVE_OR_TO_MEMORY:
            begin
                next_memWr = 1'b1;
                next_memData = xorRes; // [RQ19]
                next_flags.zero = xorRes == 8'h00;
            end
            default:
            begin
                next_skip = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // results and retire

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            memWrEn <= 1'b0;
            memWrData <= WORK_RST;
            retireValid <= 1'b0;
            skipTaken <= 1'b0;
        end
        else
        begin
            memWrEn <= state == S_EXEC && next_memWr;
            if (state == S_EXEC)
            begin
                memWrData <= next_memData;
            end
            retireValid <= state == S_EXEC;
            skipTaken <= state == S_EXEC && next_skip;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            lastSkip <= 1'b0;
            tableHighByteLatch <= LATCH_RST;
        end
        else
        begin
            if (retireValid)
            begin
                lastSkip <= skipTaken;
            end
            if (state == S_EXEC && next_latch)
            begin
                tableHighByteLatch <= progRdData[15:8]; // [RQ16] [RQ17]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus slave: one wait state; writes stall while the engine runs

    assign waitrequest = (read || write) && !busAck;
    assign busWrite = write && busAck && byteenable[0];

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            busAck <= 1'b0;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            // a write must not land while a command is being accepted
            busAck <= !busAck && (read || (write && !busy && !cmdValid));
            if (read && !busAck)
            begin
                case (address)
                    REG_WORK_OFS: readdata <= {{(BUS_DW-8){1'b0}}, workingRegister};
                    REG_FLAGS_OFS: readdata <= {{(BUS_DW-4){1'b0}}, statusFlags};
                    REG_PTR_LOW_OFS: readdata <= {{(BUS_DW-8){1'b0}}, tablePointerLow};
                    REG_PTR_HIGH_OFS: readdata <= {{(BUS_DW-8){1'b0}}, tablePointerHigh};
                    REG_LATCH_OFS: readdata <= {{(BUS_DW-8){1'b0}}, tableHighByteLatch};
                    REG_ENGINE_OFS: readdata <= {{(BUS_DW-2){1'b0}}, lastSkip, busy};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // engine writes only in S_EXEC; bus writes are only acked while idle
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            workingRegister <= WORK_RST;
            statusFlags <= FLAGS_RST;
            tablePointerLow <= PTR_RST;
            tablePointerHigh <= PTR_RST;
        end
        else if (state == S_EXEC)
        begin
            workingRegister <= next_work;
            statusFlags <= next_flags;
        end
        else if (busWrite)
        begin
            case (address)
                REG_WORK_OFS: workingRegister <= writedata[7:0];
                REG_FLAGS_OFS: statusFlags <= writedata[3:0];
                REG_PTR_LOW_OFS: tablePointerLow <= writedata[7:0];
                REG_PTR_HIGH_OFS: tablePointerHigh <= writedata[7:0];
                default: tablePointerLow <= tablePointerLow;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_exec(ssx_op_e o);
        state == S_EXEC && cmdHold.op == o;
    endsequence

    sequence s_skip_retire;
        retireValid && skipTaken;
    endsequence

    dec_skip_a: assert property (s_exec(OP_DEC_SKIP_TO_WORK_REG) |=> // [RQ1]
        workingRegister == 8'($past(memRdData) - 8'h01) && !memWrEn
        && skipTaken == ($past(memRdData) == 8'h01)) else $error("decrement skip wrong");
    skip_dummy_a: assert property (s_skip_retire |=> dummyCycle ##1 cmdReady) // [RQ2]
        else $error("skip lacks one dummy cycle");
    noskip_dummy_a: assert property (retireValid && !skipTaken |=> !dummyCycle) // [RQ2]
        else $error("dummy cycle without skip");
    set_byte_a: assert property (s_exec(OP_SET_BYTE) |=> // [RQ3]
        memWrEn && memWrData == 8'hFF && statusFlags == $past(statusFlags))
        else $error("set byte wrong");
    set_bit_a: assert property (s_exec(OP_SET_BIT) |=> memWrEn // [RQ4]
        && memWrData == ($past(memRdData) | (8'h01 << $past(cmdHold.bitSel))))
        else $error("set bit wrong");
    inc_mem_a: assert property (s_exec(OP_INC_SKIP_IN_PLACE) |=> memWrEn // [RQ5]
        && memWrData == 8'($past(memRdData) + 8'h01) && skipTaken == ($past(memRdData) == 8'hFF))
        else $error("increment in place wrong");
    inc_work_a: assert property (s_exec(OP_INC_SKIP_TO_WORK_REG) |=> !memWrEn // [RQ6]
        && workingRegister == 8'($past(memRdData) + 8'h01)) else $error("increment to work wrong");
    bit_one_a: assert property (s_exec(OP_BIT_SET_SKIP) |=> // [RQ7]
        skipTaken == $past(memRdData[cmdHold.bitSel])) else $error("bit one skip wrong");
    bit_zero_a: assert property (s_exec(OP_BIT_CLEAR_SKIP) |=> // [RQ8]
        skipTaken != $past(memRdData[cmdHold.bitSel])) else $error("bit zero skip wrong");
    zero_test_a: assert property (s_exec(OP_ZERO_TEST_SKIP) |=> !memWrEn // [RQ9]
        && $stable(workingRegister) && skipTaken == ($past(memRdData) == 8'h00))
        else $error("zero test wrong");
    copy_test_a: assert property (s_exec(OP_COPY_TEST_SKIP) |=> // [RQ10]
        workingRegister == $past(memRdData) && $stable(statusFlags)) else $error("copy test wrong");
    sub_mem_a: assert property (s_exec(OP_SUBTRACT_TO_MEMORY) |=> memWrEn // [RQ11]
        && memWrData == 8'($past(workingRegister) - $past(memRdData)) && $stable(workingRegister))
        else $error("subtract to memory wrong");
    sub_imm_a: assert property (s_exec(OP_SUBTRACT_IMMEDIATE) |=> !memWrEn // [RQ12]
        && workingRegister == 8'($past(workingRegister) - $past(cmdHold.literal)))
        else $error("immediate subtract wrong");
    sub_carry_a: assert property (state == S_EXEC && (cmdHold.op == OP_SUBTRACT_TO_WORK_REG // [RQ13]
        || cmdHold.op == OP_SUBTRACT_TO_MEMORY || cmdHold.op == OP_SUBTRACT_IMMEDIATE)
        |=> statusFlags.carry == ($past(subA) >= $past(subB))) else $error("carry wrong");
    swap_mem_a: assert property (s_exec(OP_NIBBLE_EXCHANGE) |=> memWrEn // [RQ14]
        && memWrData == {$past(memRdData[3:0]), $past(memRdData[7:4])}) else $error("swap wrong");
    table_read_a: assert property (s_exec(OP_PROGRAM_WORD_READ) |=> memWrEn // [RQ16]
        && memWrData == $past(progRdData[7:0]) && tableHighByteLatch == $past(progRdData[15:8]))
        else $error("table read wrong");
    last_page_a: assert property (progRdEn && cmdHold.op == OP_LAST_PAGE_WORD_READ |-> // [RQ17]
        progAddr[7:0] == tablePointerLow && &progAddr[PROG_AW-1:8]) else $error("last page wrong");
    xor_mem_a: assert property (s_exec(OP_EXCLUSIVE_OR_TO_MEMORY) |=> memWrEn // [RQ19]
        && memWrData == ($past(workingRegister) ^ $past(memRdData))
        && statusFlags.carry == $past(statusFlags.carry)) else $error("xor to memory wrong");

endmodule

// [test/ssx_mem_model.sv]
/*
  Data and program memory on the far side of the execution unit.
  Assumes reads are answered the cycle after the enable and writes land at the edge.
*/
`timescale 1ns/100ps
module ssx_mem_model
    import ssx_pkg::*;
#(
    parameter int PROG_AW = 11
) (
    // clock
    input wire logic clk,
    // data memory
    input wire logic [DMEM_AW-1:0] memAddr,
    input wire logic memRdEn,
    output logic [DATA_W-1:0] memRdData,
    input wire logic memWrEn,
    input wire logic [DATA_W-1:0] memWrData,
    // program memory
    input wire logic [PROG_AW-1:0] progAddr,
    input wire logic progRdEn,
    output logic [PROG_DW-1:0] progRdData
);
    logic [DATA_W-1:0] dmem [256];
    logic [DATA_W-1:0] rdq = 8'h00;
    logic [PROG_DW-1:0] pwq = 16'h0000;

    // the low byte depends on the upper address bits, so a wrong page shows
    function automatic logic [PROG_DW-1:0] pw(input logic [PROG_AW-1:0] a);
        return {a[7:0] ^ 8'hC3, a[PROG_AW-1:PROG_AW-8]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // outside the answer cycle the lines toggle, so stale data never matches
    always @(posedge clk)
    begin
        rdq <= memRdEn ? dmem[memAddr] : ~rdq;
        pwq <= progRdEn ? pw(progAddr) : ~pwq;
        if (memWrEn)
            dmem[memAddr] <= memWrData;
    end
    assign memRdData = rdq;
    assign progRdData = pwq;
endmodule

// [test/test_skip_sub_swap_xor_exec.sv]
/*
  Self-checking bench: bus and command tasks, then a table of instruction cases.
  Assumes ssx_mem_model stands in for data and program memory.
*/
`timescale 1ns/100ps
module test_skip_sub_swap_xor_exec;
    import ssx_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [BUS_AW-1:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [BUS_DW-1:0] writedata = 32'h00000000;
    logic [BUS_DW-1:0] readdata;
    logic waitrequest;
    logic cmdValid = 1'b0;
    ssx_cmd_s cmd = '0;
    logic cmdReady, retireValid, skipTaken, dummyCycle, memRdEn, memWrEn, progRdEn;
    logic [DATA_W-1:0] workingRegister, memRdData, memWrData, q;
    ssx_flags_s statusFlags;
    logic [DMEM_AW-1:0] memAddr;
    logic [10:0] progAddr;
    logic [PROG_DW-1:0] progRdData, pword;
    int fails = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    ssx_exec_unit dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
        .retireValid(retireValid), .skipTaken(skipTaken), .dummyCycle(dummyCycle),
        .workingRegister(workingRegister), .statusFlags(statusFlags), .memAddr(memAddr),
        .memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn),
        .memWrData(memWrData), .progAddr(progAddr), .progRdEn(progRdEn),
        .progRdData(progRdData));
    ssx_mem_model mem (.clk(clk), .memAddr(memAddr), .memRdEn(memRdEn),
        .memRdData(memRdData), .memWrEn(memWrEn), .memWrData(memWrData),
        .progAddr(progAddr), .progRdEn(progRdEn), .progRdData(progRdData));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task give_verdict;
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        read <= !wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            fails++;
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    function automatic logic [3:0] subf(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] d;
        d = {1'b0, a} - {1'b0, b};
        return {(a[7] ^ b[7]) & (a[7] ^ d[7]), d[7:0] == 8'h00, a[3:0] >= b[3:0], !d[8]};
    endfunction

    task run(input ssx_op_e op, input logic [7:0] adr, input logic [2:0] b,
        input logic [7:0] lit, input logic [7:0] m, input logic [7:0] w,
        input logic [3:0] f, input logic [7:0] eW, input logic [7:0] eM,
        input logic eS, input logic [3:0] eF);
        int n;
        n = 0;
        bus(1'b1, REG_WORK_OFS, w);
        bus(1'b1, REG_FLAGS_OFS, {4'h0, f});
        mem.dmem[adr] = m;
        @(posedge clk);
        cmdValid <= 1'b1;
        cmd <= '{op, adr, b, lit};
        @(posedge clk);
        cmdValid <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end while (retireValid !== 1'b1 && n < 20);
        if (n >= 20)
            fails++;
        chk("skip", {7'h00, eS}, {7'h00, skipTaken});
        chk("work", eW, workingRegister);
        chk("flags", {4'h0, eF}, {4'h0, statusFlags});
        @(posedge clk);
        chk("dummy", {7'h00, eS}, {7'h00, dummyCycle});
        chk("mem", eM, mem.dmem[adr]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict;
    end

    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        run(OP_DEC_SKIP_TO_WORK_REG, 8'h10, 3'h0, 8'h00, 8'h01, 8'h55, 4'hA, 8'h00, 8'h01, 1'b1, 4'hA);
        run(OP_DEC_SKIP_TO_WORK_REG, 8'h11, 3'h0, 8'h00, 8'h00, 8'h55, 4'hA, 8'hFF, 8'h00, 1'b0, 4'hA);
        run(OP_SET_BYTE, 8'h12, 3'h0, 8'h00, 8'h12, 8'h55, 4'hA, 8'h55, 8'hFF, 1'b0, 4'hA);
        run(OP_SET_BIT, 8'h13, 3'h7, 8'h00, 8'h12, 8'h55, 4'h5, 8'h55, 8'h92, 1'b0, 4'h5);
        run(OP_INC_SKIP_IN_PLACE, 8'h14, 3'h0, 8'h00, 8'hFF, 8'h55, 4'hA, 8'h55, 8'h00, 1'b1, 4'hA);
        run(OP_INC_SKIP_TO_WORK_REG, 8'h15, 3'h0, 8'h00, 8'hFF, 8'h55, 4'hA, 8'h00, 8'hFF, 1'b1, 4'hA);
        run(OP_INC_SKIP_TO_WORK_REG, 8'h16, 3'h0, 8'h00, 8'h7F, 8'h55, 4'hA, 8'h80, 8'h7F, 1'b0, 4'hA);
        run(OP_BIT_SET_SKIP, 8'h17, 3'h3, 8'h00, 8'h08, 8'h55, 4'hA, 8'h55, 8'h08, 1'b1, 4'hA);
        run(OP_BIT_SET_SKIP, 8'h18, 3'h3, 8'h00, 8'hF7, 8'h55, 4'hA, 8'h55, 8'hF7, 1'b0, 4'hA);
        run(OP_BIT_CLEAR_SKIP, 8'h19, 3'h0, 8'h00, 8'hFE, 8'h55, 4'hA, 8'h55, 8'hFE, 1'b1, 4'hA);
        run(OP_BIT_CLEAR_SKIP, 8'h1A, 3'h0, 8'h00, 8'h01, 8'h55, 4'hA, 8'h55, 8'h01, 1'b0, 4'hA);
        run(OP_ZERO_TEST_SKIP, 8'h1B, 3'h0, 8'h00, 8'h00, 8'h55, 4'hA, 8'h55, 8'h00, 1'b1, 4'hA);
        run(OP_ZERO_TEST_SKIP, 8'h1B, 3'h0, 8'h00, 8'h80, 8'h55, 4'hA, 8'h55, 8'h80, 1'b0, 4'hA);
        run(OP_COPY_TEST_SKIP, 8'h1C, 3'h0, 8'h00, 8'h00, 8'h55, 4'hA, 8'h00, 8'h00, 1'b1, 4'hA);
        bus(1'b0, REG_ENGINE_OFS, 8'h00);
        chk("engine", 8'h02, q);
        run(OP_COPY_TEST_SKIP, 8'h1C, 3'h0, 8'h00, 8'h5A, 8'h55, 4'hA, 8'h5A, 8'h5A, 1'b0, 4'hA);
        run(OP_SUBTRACT_TO_WORK_REG, 8'h20, 3'h0, 8'h00, 8'h20, 8'h10, 4'hF, 8'hF0, 8'h20, 1'b0, subf(8'h10, 8'h20));
        run(OP_SUBTRACT_TO_MEMORY, 8'h21, 3'h0, 8'h00, 8'h01, 8'h80, 4'h0, 8'h80, 8'h7F, 1'b0, subf(8'h80, 8'h01));
        run(OP_SUBTRACT_IMMEDIATE, 8'h22, 3'h0, 8'h33, 8'h00, 8'h33, 4'h0, 8'h00, 8'h00, 1'b0, subf(8'h33, 8'h33));
        run(OP_SUBTRACT_IMMEDIATE, 8'h22, 3'h0, 8'h0F, 8'h00, 8'h08, 4'hF, 8'hF9, 8'h00, 1'b0, subf(8'h08, 8'h0F));
        run(OP_NIBBLE_EXCHANGE, 8'h23, 3'h0, 8'h00, 8'hA5, 8'h55, 4'hA, 8'h55, 8'h5A, 1'b0, 4'hA);
        run(OP_NIBBLE_EXCHANGE_TO_WORK_REG, 8'h24, 3'h0, 8'h00, 8'h3C, 8'h55, 4'hA, 8'hC3, 8'h3C, 1'b0, 4'hA);
        run(OP_EXCLUSIVE_OR_TO_WORK_REG, 8'h25, 3'h0, 8'h00, 8'hF0, 8'hF0, 4'hA, 8'h00, 8'hF0, 1'b0, 4'hE);
        run(OP_EXCLUSIVE_OR_IMMEDIATE, 8'h26, 3'h0, 8'h0F, 8'h00, 8'hF0, 4'hE, 8'hFF, 8'h00, 1'b0, 4'hA);
        run(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h27, 3'h0, 8'h00, 8'h3C, 8'h0F, 4'hA, 8'h0F, 8'h33, 1'b0, 4'hA);
        bus(1'b1, REG_PTR_LOW_OFS, 8'h21);
        bus(1'b1, REG_PTR_HIGH_OFS, 8'h05);
        pword = mem.pw(11'h521);
        run(OP_PROGRAM_WORD_READ, 8'h28, 3'h0, 8'h00, 8'h00, 8'h55, 4'hA, 8'h55, pword[7:0], 1'b0, 4'hA);
        bus(1'b0, REG_LATCH_OFS, 8'h00);
        chk("latch", pword[15:8], q);
        pword = mem.pw(11'h721);
        run(OP_LAST_PAGE_WORD_READ, 8'h29, 3'h0, 8'h00, 8'h00, 8'h55, 4'hA, 8'h55, pword[7:0], 1'b0, 4'hA);
        // the latch is read-only from the bus side
        bus(1'b1, REG_LATCH_OFS, 8'h00);
        bus(1'b0, REG_LATCH_OFS, 8'h00);
        chk("latch", pword[15:8], q);
        bus(1'b0, REG_WORK_OFS, 8'h00);
        chk("work bus", 8'h55, q);
        bus(1'b0, 5'h18, 8'h00);
        chk("unmapped", 8'h00, q);
        give_verdict;
    end
endmodule
